/* design/dwsl_pkg.sv */
// Constants shared by the dual wiper serial loader.
// Function
// - Shift data in on rising clock while selected
// - Select rising loads word into chosen wiper
// - Surplus early bits dropped, last nine kept
// - Bit 8 picks wiper, bits 7..0 code
// - Wipers preset to midscale at power-up
// - Wiper settings held only while powered
// - Code decodes to one of 256 taps
package dwsl_pkg;

   localparam int WORD_W = 9;
   localparam int CODE_W = 8;
   localparam int CHAN_BIT = 8;
   localparam int NUM_WIPERS = 2;
   localparam int TAP_N = 256;
   localparam int MID_TAP = 128;

   localparam logic [CODE_W-1:0] MID_CODE = 8'h80;
   localparam logic [TAP_N-1:0] TAP_ONE = 256'h1;

endpackage : dwsl_pkg

/* design/dwsl_loader.sv */
// Three-wire serial receive port feeding two wiper registers and tap decoders.
`timescale 1ns/1ps

module dwsl_loader (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_data_in,
   output logic [dwsl_pkg::CODE_W-1:0] wiper0_code,
   output logic [dwsl_pkg::CODE_W-1:0] wiper1_code,
   output logic [dwsl_pkg::TAP_N-1:0] tap0_sel,
   output logic [dwsl_pkg::TAP_N-1:0] tap1_sel,
   output logic word_loaded
);
   import dwsl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: serial input register

   logic [WORD_W-1:0] shift_word;

   // Link clock is idle at power-up, so the clear cannot wait for one of its edges
   always_ff @(posedge sclk or posedge srst) begin
      if (srst) begin
         shift_word <= '0;
      end else if (!cs_n) begin
         // Older bits fall off the top, so only the last nine stay
         shift_word <= {shift_word[WORD_W-2:0], serial_data_in};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Select crossing into ref_clk domain

   logic cs_n_meta;
   logic cs_n_sync;
   logic cs_n_prev;
   logic cs_rise;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cs_n_meta <= 1'b1;
         cs_n_sync <= 1'b1;
         cs_n_prev <= 1'b1;
      end else begin
         cs_n_meta <= cs_n;
         cs_n_sync <= cs_n_meta;
         cs_n_prev <= cs_n_sync;
      end
   end

   // Serial clock is idle once select is high, so the word is static here
   assign cs_rise = cs_n_sync & ~cs_n_prev;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         word_loaded <= 1'b0;
      end else begin
         word_loaded <= cs_rise;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wiper registers and tap decoders

   generate
      for (genvar w = 0; w < NUM_WIPERS; w++) begin : g_wiper
         logic [CODE_W-1:0] code;
         logic [TAP_N-1:0] tap;

         // Reset stands for power-up; nothing survives it
         always_ff @(posedge ref_clk) begin
            if (srst) begin
               code <= MID_CODE;
            end else if (cs_rise && (shift_word[CHAN_BIT] == 1'(w))) begin
               code <= shift_word[CODE_W-1:0];
            end
         end

         for (genvar t = 0; t < TAP_N; t++) begin : g_tap
            always_ff @(posedge ref_clk) begin
               if (srst) begin
                  tap[t] <= (CODE_W'(t) == MID_CODE);
               end else begin
                  tap[t] <= (code == CODE_W'(t));
               end
            end
         end
      end
   endgenerate

   assign wiper0_code = g_wiper[0].code;
   assign wiper1_code = g_wiper[1].code;
   assign tap0_sel = g_wiper[0].tap;
   assign tap1_sel = g_wiper[1].tap;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions: link domain

   sequence s_bit_shifted;
      !cs_n;
   endsequence

   sequence s_two_bits;
      !cs_n ##1 !cs_n;
   endsequence

   property p_shift_in;
      @(posedge sclk) disable iff (cs_n)
      s_bit_shifted |=> (shift_word[0] == $past(serial_data_in));
   endproperty
   a_shift_in: assert property (p_shift_in)
      else $error("serial input bit not captured");

   property p_keep_last_nine;
      @(posedge sclk) disable iff (cs_n)
      s_two_bits |-> (shift_word[WORD_W-1:1] == $past(shift_word[WORD_W-2:0]));
   endproperty
   a_keep_last_nine: assert property (p_keep_last_nine)
      else $error("serial register did not shift toward the top");

   sequence s_three_bits;
      !cs_n [*3];
   endsequence

   // A bit taken two edges back now sits one place up
   property p_bit_moves_up;
      @(posedge sclk) disable iff (cs_n)
      s_three_bits |-> (shift_word[1] == $past(serial_data_in, 2));
   endproperty
   a_bit_moves_up: assert property (p_bit_moves_up)
      else $error("serial bit did not move up one place per edge");

   ////////////////////////////////////////////////////////////////////////////
   // Assertions: ref_clk domain

   sequence s_load0;
      cs_rise && !shift_word[CHAN_BIT];
   endsequence

   sequence s_load1;
      cs_rise && shift_word[CHAN_BIT];
   endsequence

   sequence s_pulse;
      word_loaded ##1 !word_loaded;
   endsequence

   property p_load_wiper0;
      @(posedge ref_clk) disable iff (srst)
      s_load0 |=> (wiper0_code == $past(shift_word[CODE_W-1:0])) && $stable(wiper1_code);
   endproperty
   a_load_wiper0: assert property (p_load_wiper0)
      else $error("wiper 0 not loaded on select rise");

   property p_load_wiper1;
      @(posedge ref_clk) disable iff (srst)
      s_load1 |=> (wiper1_code == $past(shift_word[CODE_W-1:0])) && $stable(wiper0_code);
   endproperty
   a_load_wiper1: assert property (p_load_wiper1)
      else $error("channel bit did not steer load to wiper 1");

   property p_hold;
      @(posedge ref_clk) disable iff (srst)
      !cs_rise |=> $stable(wiper0_code) && $stable(wiper1_code);
   endproperty
   a_hold: assert property (p_hold)
      else $error("wiper changed without a load");

   property p_preset;
      @(posedge ref_clk) disable iff (1'b0)
      srst |=> (wiper0_code == MID_CODE) && (wiper1_code == MID_CODE);
   endproperty
   a_preset: assert property (p_preset)
      else $error("wipers not at midscale after reset");

   property p_mid_tap;
      @(posedge ref_clk) disable iff (1'b0)
      srst |=> tap0_sel[MID_TAP] && tap1_sel[MID_TAP] && $onehot(tap0_sel);
   endproperty
   a_mid_tap: assert property (p_mid_tap)
      else $error("reset tap is not the midscale tap");

   property p_tap_decode;
      @(posedge ref_clk) disable iff (srst)
      !$past(srst) |-> (tap0_sel == (TAP_ONE << $past(wiper0_code)))
         && (tap1_sel == (TAP_ONE << $past(wiper1_code)));
   endproperty
   a_tap_decode: assert property (p_tap_decode)
      else $error("tap select does not follow wiper code");

   property p_load_pulse;
      @(posedge ref_clk) disable iff (srst)
      cs_rise |=> s_pulse;
   endproperty
   a_load_pulse: assert property (p_load_pulse)
      else $error("load pulse missing or stretched");

   property p_tap_onehot;
      @(posedge ref_clk) disable iff (srst)
      $onehot(tap0_sel) && $onehot(tap1_sel);
   endproperty
   a_tap_onehot: assert property (p_tap_onehot)
      else $error("tap select is not a single tap");

   sequence s_zero_code;
      wiper0_code == '0;
   endsequence

   // Code zero sits at the B end, bit 0
   property p_zero_code_b_end;
      @(posedge ref_clk) disable iff (srst)
      s_zero_code |=> tap0_sel[0];
   endproperty
   a_zero_code_b_end: assert property (p_zero_code_b_end)
      else $error("code zero did not select the B end tap");

   sequence s_full_code;
      wiper1_code == '1;
   endsequence

   property p_full_code_top;
      @(posedge ref_clk) disable iff (srst)
      s_full_code |=> tap1_sel[TAP_N-1];
   endproperty
   a_full_code_top: assert property (p_full_code_top)
      else $error("full code did not select the top tap");

   property p_reset_no_load;
      @(posedge ref_clk) disable iff (1'b0)
      srst |=> !word_loaded && !cs_rise;
   endproperty
   a_reset_no_load: assert property (p_reset_no_load)
      else $error("load pulse seen during reset");

endmodule : dwsl_loader

/* dv/dwsl_ctrl_model.sv */
// Serial controller model that sends frames to the loader.
`timescale 1ns/1ps
module dwsl_ctrl_model (
   output logic sclk,
   output logic cs_n,
   output logic serial_data_in
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      serial_data_in = 1'b0;
   end
   // Clock out n bits of w, MSB first, 32 ns period
   task automatic send(input logic [15:0] w, input int n);
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_in = w[i];
         #16 sclk = 1'b1;
         #16 sclk = 1'b0;
      end
      #16 cs_n = 1'b1;
      // Released line shows no stale bit
      serial_data_in = ~serial_data_in;
   endtask : send
endmodule : dwsl_ctrl_model

/* dv/dual_wiper_serial_loader_test.sv */
// Self-checking bench for the dual wiper serial loader.
`timescale 1ns/1ps
module dual_wiper_serial_loader_test;
   import dwsl_pkg::*;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic sclk, cs_n, serial_data_in, word_loaded;
   logic [CODE_W-1:0] wiper0_code, wiper1_code;
   logic [TAP_N-1:0] tap0_sel, tap1_sel;
   int mismatches = 0;
   int checked = 0;
   always #5 ref_clk = ~ref_clk;
   dwsl_ctrl_model ctrl_u (.sclk(sclk), .cs_n(cs_n), .serial_data_in(serial_data_in));
   dwsl_loader dut_u (.ref_clk(ref_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
      .serial_data_in(serial_data_in), .wiper0_code(wiper0_code),
      .wiper1_code(wiper1_code), .tap0_sel(tap0_sel), .tap1_sel(tap1_sel),
      .word_loaded(word_loaded));
   task automatic check(input string what, input logic [TAP_N-1:0] seen,
         input logic [TAP_N-1:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic expect_wipers(input logic [CODE_W-1:0] c0, input logic [CODE_W-1:0] c1);
      check("wiper0_code", TAP_N'(wiper0_code), TAP_N'(c0));
      check("wiper1_code", TAP_N'(wiper1_code), TAP_N'(c1));
      check("tap0_sel", tap0_sel, TAP_ONE << c0);
      check("tap1_sel", tap1_sel, TAP_ONE << c1);
   endtask : expect_wipers
   task automatic load(input logic [15:0] w, input int n);
      int k = 0;
      ctrl_u.send(w, n);
      while (word_loaded !== 1'b1 && k < 20) begin
         @(posedge ref_clk);
         #1 k++;
      end
      check("word_loaded", TAP_N'(word_loaded), TAP_N'(1));
      @(posedge ref_clk);
      #1;
   endtask : load
   task automatic end_of_test;
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #100000;
      mismatches++;
      end_of_test;
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      #1 srst = 1'b0;
      expect_wipers(MID_CODE, MID_CODE);
      load(16'h03c, 9);
      expect_wipers(8'h3c, MID_CODE);
      load(16'h1a5, 9);
      expect_wipers(8'h3c, 8'ha5);
      // Three surplus leading bits point at the other wiper
      load(16'he01, 12);
      expect_wipers(8'h01, 8'ha5);
      load(16'h1ff, 9);
      expect_wipers(8'h01, 8'hff);
      load(16'h000, 9);
      expect_wipers(8'h00, 8'hff);
      // Power cycle loses both settings
      srst = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 srst = 1'b0;
      expect_wipers(MID_CODE, MID_CODE);
      load(16'h15a, 9);
      expect_wipers(MID_CODE, 8'h5a);
      end_of_test;
   end
endmodule : dual_wiper_serial_loader_test
